// [core/sbl_device.sv]
`timescale 1ns/100ps
`include "sbl_map.svh"
// Overview of operation
// RULE1 - Chip select high or nop: continue operation.
// RULE2 - Decode only with clock enable high twice.
// RULE3 - Track idle and row active per bank.
// RULE4 - Idle bank n never blocks bank m.
// RULE5 - Accept active, read, write, precharge cross-bank.
// RULE6 - Refresh and mode load need all idle.
// RULE7 - Burst stop acts on current burst bank.
// RULE8 - Unlisted combinations are controller's fault.
// RULE9 - Interrupted auto precharge burst starts precharge.
// RULE10 - Precharge elsewhere leaves running burst alone.
// RULE11 - New read data replaces after latency.
// RULE12 - Write cuts read; mask one clock before.
// RULE13 - Read ends write; data after latency.
// RULE14 - Write ends write; last word before.
// RULE15 - Read interrupts auto precharge read, precharges.
// RULE16 - Write ends auto precharge read, precharges.
// RULE17 - Read ends auto precharge write, recovery.
// RULE18 - Write ends auto precharge write, recovery.
// RULE19 - Clock enable low twice keeps low-power mode.
// RULE20 - Clock enable falling enters low-power modes.
// RULE21 - Power-down exit idle by next edge.
// RULE22 - Self refresh exit waits exit time.
// RULE23 - Suspend exit resumes, decodes next edge.
// RULE24 - Independent state record per bank.
module sbl_device #(
   parameter int CAS_LAT = `SBL_CAS_LATENCY,
   parameter int BURST_LEN = `SBL_BURST_LEN
) (
   input wire logic ref_clk,
   input wire logic nrst,
   sbl_if.dev pins,
   output logic [11:0] bank_state,
   output logic [2:0] mode,
   output logic data_out_valid,
   output logic [1:0] data_out_bank,
   output logic data_in_take,
   output logic [1:0] data_in_bank,
   output logic cmd_accept
);
   localparam int NB = `SBL_NUM_BANKS;
   localparam int PRECHARGE_TIME = `SBL_PRECHARGE_CYC;
   localparam int ACTIVATE_TO_COLUMN_DELAY = `SBL_ACT_TO_COL_CYC;
   localparam int WRITE_RECOVERY_TIME = `SBL_WRITE_RECOVERY_CYC;
   localparam int SELF_REFRESH_EXIT_TIME = `SBL_SR_EXIT_CYC;
   initial
   begin
      if (CAS_LAT < 1 || CAS_LAT > 7 || BURST_LEN < 1 || BURST_LEN > 15)
         $error("sbl_device: unsupported latency or burst length");
   end

   // Pins come from another device: two flip-flops each before use.
   logic [8:0] s1_reg, s2_reg;
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         s1_reg <= 9'h0f0;
         s2_reg <= 9'h0f0;
      end
      else
      begin
         s1_reg <= {pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n,
            pins.ba, pins.auto_pre, pins.dqm};
         s2_reg <= s1_reg;
      end

   // Decoded command at this edge.
   wire cke_now = s2_reg[8];
   wire cs_n = s2_reg[7];
   wire [2:0] code = s2_reg[6:4];
   wire [1:0] ba = s2_reg[3:2];
   wire ap = s2_reg[1];
   logic cke_prev_reg;
   sbl_pkg::sbl_mode_t mode_reg, mode_next;
   logic [7:0] mcnt_reg;
   // An inhibited or nop command changes nothing. RULE1
   wire is_nop = cs_n || (code == 3'h7);
   wire run = (mode_reg == sbl_pkg::SBL_MD_NORMAL) && cke_prev_reg
      && cke_now; // RULE2
   wire c_act = run && !cs_n && code == sbl_pkg::SBL_CMD_ACTIVE;
   wire c_rd = run && !cs_n && code == sbl_pkg::SBL_CMD_READ;
   wire c_wr = run && !cs_n && code == sbl_pkg::SBL_CMD_WRITE;
   wire c_pre = run && !cs_n && code == sbl_pkg::SBL_CMD_PRECHARGE;
   wire c_stop = run && !cs_n && code == sbl_pkg::SBL_CMD_BURST_STOP;
   wire c_ref = !cs_n && code == sbl_pkg::SBL_CMD_REFRESH;
   wire c_col = c_rd || c_wr;

   // Per-bank records. RULE24
   sbl_pkg::sbl_bank_t bst_reg [NB];
   logic [3:0] bcnt_reg [NB];
   logic [3:0] burst_reg [NB];
   logic bap_reg [NB];
   logic [NB-1:0] idle_w;
   logic [1:0] cur_reg;
   logic busy_reg;
   wire all_idle = &idle_w;
   // RULE6 RULE8 are kept by the controller; here only power-down and self refresh entry check all_idle.

   genvar g;
   generate
      for (g = 0; g < NB; g++)
      begin : gb
         wire hit = (ba == 2'(g));
         wire bursting = bst_reg[g] == sbl_pkg::SBL_BK_READ
            || bst_reg[g] == sbl_pkg::SBL_BK_WRITE;
         // Another bank's column command or a stop ends this burst.
         wire cut = bursting && ((c_col && !hit) // RULE11 RULE12 RULE13 RULE14
            || (c_stop && cur_reg == 2'(g))); // RULE7
         wire is_wr = bst_reg[g] == sbl_pkg::SBL_BK_WRITE;
         assign idle_w[g] = bst_reg[g] == sbl_pkg::SBL_BK_IDLE;
         always_ff @(posedge ref_clk or negedge nrst)
            if (!nrst)
            begin
               bst_reg[g] <= sbl_pkg::SBL_BK_IDLE;
               bcnt_reg[g] <= 4'h0;
               burst_reg[g] <= 4'h0;
               bap_reg[g] <= 1'b0;
            end
            else if (run)
            begin
               if (bcnt_reg[g] != 4'h0)
                  bcnt_reg[g] <= bcnt_reg[g] - 4'h1;
               if (burst_reg[g] != 4'h0)
                  burst_reg[g] <= burst_reg[g] - 4'h1;
               case (bst_reg[g])
                  sbl_pkg::SBL_BK_IDLE:
                     if (c_act && hit)
                     begin
                        bst_reg[g] <= sbl_pkg::SBL_BK_ACTIVATING;
                        bcnt_reg[g] <= 4'(ACTIVATE_TO_COLUMN_DELAY - 1);
                     end
                  sbl_pkg::SBL_BK_ACTIVATING:
                     if (bcnt_reg[g] == 4'h0)
                        bst_reg[g] <= sbl_pkg::SBL_BK_ACTIVE; // RULE3
                  sbl_pkg::SBL_BK_ACTIVE, sbl_pkg::SBL_BK_READ,
                  sbl_pkg::SBL_BK_WRITE:
                     if (c_col && hit)
                     begin
                        bst_reg[g] <= c_rd ? sbl_pkg::SBL_BK_READ
                           : sbl_pkg::SBL_BK_WRITE;
                        burst_reg[g] <= 4'(BURST_LEN - 1);
                        bap_reg[g] <= ap;
                     end
                     else if (c_pre && hit)
                     begin
                        bst_reg[g] <= sbl_pkg::SBL_BK_PRECHARGING;
                        bcnt_reg[g] <= 4'(PRECHARGE_TIME - 1);
                     end
                     else if (cut || (bursting && burst_reg[g] == 4'h0))
                     begin
                        // Auto precharge starts on interruption too. RULE9
                        if (bap_reg[g])
                        begin
                           bst_reg[g] <= sbl_pkg::SBL_BK_PRECHARGING;
                           // Writes wait for recovery first. RULE17 RULE18
                           bcnt_reg[g] <= is_wr ? 4'(WRITE_RECOVERY_TIME + PRECHARGE_TIME - 1)
                              : 4'(PRECHARGE_TIME - 1); // RULE15 RULE16
                        end
                        else
                           bst_reg[g] <= sbl_pkg::SBL_BK_ACTIVE;
                     end
                  // Foreign precharge reaches none of the above. RULE10
                  sbl_pkg::SBL_BK_PRECHARGING:
                     if (bcnt_reg[g] == 4'h0)
                        bst_reg[g] <= sbl_pkg::SBL_BK_IDLE; // RULE3
                  default:
                     bst_reg[g] <= sbl_pkg::SBL_BK_IDLE;
               endcase
            end
         assign bank_state[3*g +: 3] = bst_reg[g];
      end
   endgenerate

   // Most recent burst owner, for burst stop and data steering.
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         cur_reg <= 2'h0;
         busy_reg <= 1'b0;
      end
      else if (c_col)
      begin
         cur_reg <= ba;
         busy_reg <= 1'b1;
      end

   // Read data path: a shift line of latency stages. RULE11 RULE13
   // While suspended the line is frozen, so its tap must not pulse again.
   logic [7:0] rd_pipe_reg;
   wire rd_hold = !cke_prev_reg && mode_reg == sbl_pkg::SBL_MD_SUSPEND;
   logic [15:0] rd_bank_reg;
   wire rd_beat = c_rd
      || (bst_reg[cur_reg] == sbl_pkg::SBL_BK_READ && !c_wr && !c_stop
      && burst_reg[cur_reg] != 4'h0 && run);
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         rd_pipe_reg <= 8'h00;
         rd_bank_reg <= 16'h0000;
      end
      else if (rd_hold)
      begin
         rd_pipe_reg <= rd_pipe_reg;
      end
      else
      begin
         rd_pipe_reg <= {rd_pipe_reg[6:0], rd_beat};
         rd_bank_reg <= {rd_bank_reg[13:0], c_rd ? ba : cur_reg};
      end

   // Write data is taken on the write edge and following beats; a
   // column command or a burst stop ends it, so the last word is one clock earlier.
   wire wr_beat = c_wr || (bst_reg[cur_reg] == sbl_pkg::SBL_BK_WRITE
      && !c_col && !c_stop && burst_reg[cur_reg] != 4'h0 && run);

   // Clock-enable mode machine. RULE19 RULE20 RULE21 RULE22 RULE23
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         sbl_pkg::SBL_MD_NORMAL:
            if (cke_prev_reg && !cke_now)
            begin
               if (all_idle && is_nop)
                  mode_next = sbl_pkg::SBL_MD_POWER_DOWN; // RULE20
               else if (all_idle && c_ref)
                  mode_next = sbl_pkg::SBL_MD_SELF_REFRESH;
               else if (busy_reg)
                  mode_next = sbl_pkg::SBL_MD_SUSPEND;
            end
         sbl_pkg::SBL_MD_POWER_DOWN:
            if (cke_now && is_nop)
               mode_next = sbl_pkg::SBL_MD_NORMAL; // RULE21
         sbl_pkg::SBL_MD_SELF_REFRESH:
            if (cke_now && is_nop)
               mode_next = sbl_pkg::SBL_MD_SR_EXIT; // RULE22
         sbl_pkg::SBL_MD_SR_EXIT:
            if (mcnt_reg == 8'h00)
               mode_next = sbl_pkg::SBL_MD_NORMAL;
         sbl_pkg::SBL_MD_SUSPEND:
            if (cke_now)
               mode_next = sbl_pkg::SBL_MD_NORMAL; // RULE23
         default:
            mode_next = sbl_pkg::SBL_MD_NORMAL;
      endcase
   end

   // The exit counter loads on entry so it is ready at the exit edge.
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         mode_reg <= sbl_pkg::SBL_MD_NORMAL;
         cke_prev_reg <= 1'b0;
         mcnt_reg <= 8'h00;
      end
      else
      begin
         mode_reg <= mode_next;
         cke_prev_reg <= cke_now;
         if (mode_next == sbl_pkg::SBL_MD_SR_EXIT
            && mode_reg != sbl_pkg::SBL_MD_SR_EXIT)
            mcnt_reg <= 8'(SELF_REFRESH_EXIT_TIME - 1);
         else if (mcnt_reg != 8'h00)
            mcnt_reg <= mcnt_reg - 8'h01;
      end

   // Registered status outputs.
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         mode <= 3'h0;
         data_out_valid <= 1'b0;
         data_out_bank <= 2'h0;
         data_in_take <= 1'b0;
         data_in_bank <= 2'h0;
         cmd_accept <= 1'b0;
      end
      else
      begin
         mode <= mode_next;
         data_out_valid <= !rd_hold && rd_pipe_reg[CAS_LAT - 1]; // RULE23
         data_out_bank <= rd_bank_reg[2*(CAS_LAT - 1) +: 2];
         data_in_take <= wr_beat;
         data_in_bank <= c_wr ? ba : cur_reg;
         cmd_accept <= run && !is_nop; // RULE4 RULE5
      end
endmodule // sbl_device

// [pkg/sbl_map.svh]
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH
// Timing figures in nanoseconds and the clock period.
`define SBL_CLK_PERIOD_NS 25
`define SBL_PRECHARGE_TIME_NS 20
`define SBL_ACT_TO_COL_NS 20
`define SBL_WRITE_RECOVERY_NS 15
`define SBL_SR_EXIT_NS 75
// Least times round up to whole cycles, never below one.
`define SBL_CYC(ns) (((ns) + `SBL_CLK_PERIOD_NS - 1) / `SBL_CLK_PERIOD_NS)
`define SBL_PRECHARGE_CYC `SBL_CYC(`SBL_PRECHARGE_TIME_NS)
`define SBL_ACT_TO_COL_CYC `SBL_CYC(`SBL_ACT_TO_COL_NS)
`define SBL_WRITE_RECOVERY_CYC `SBL_CYC(`SBL_WRITE_RECOVERY_NS)
`define SBL_SR_EXIT_CYC `SBL_CYC(`SBL_SR_EXIT_NS)
// Reset values and defaults.
`define SBL_CAS_LATENCY 3
`define SBL_BURST_LEN 4
`define SBL_NUM_BANKS 4
`endif

// [pkg/sbl_pkg.sv]
package sbl_pkg;
   // Command codes: row strobe, column strobe, write enable (active low).
   typedef enum logic [2:0] {
      SBL_CMD_NOP = 3'h7,
      SBL_CMD_ACTIVE = 3'h3,
      SBL_CMD_READ = 3'h5,
      SBL_CMD_WRITE = 3'h4,
      SBL_CMD_PRECHARGE = 3'h2,
      SBL_CMD_REFRESH = 3'h1,
      SBL_CMD_LOAD_MODE = 3'h0,
      SBL_CMD_BURST_STOP = 3'h6
   } sbl_cmd_t;
   // Per-bank state.
   typedef enum logic [2:0] {
      SBL_BK_IDLE = 3'h0,
      SBL_BK_ACTIVATING = 3'h1,
      SBL_BK_ACTIVE = 3'h3,
      SBL_BK_READ = 3'h2,
      SBL_BK_WRITE = 3'h6,
      SBL_BK_PRECHARGING = 3'h4
   } sbl_bank_t;
   // Clock-enable driven device mode.
   typedef enum logic [2:0] {
      SBL_MD_NORMAL = 3'h0,
      SBL_MD_POWER_DOWN = 3'h1,
      SBL_MD_SELF_REFRESH = 3'h3,
      SBL_MD_SR_EXIT = 3'h2,
      SBL_MD_SUSPEND = 3'h6
   } sbl_mode_t;
endpackage

// [pkg/sbl_if.sv]
`timescale 1ns/100ps
// Command pins between controller and device; cs_n, ras_n, cas_n and we_n are active low.
interface sbl_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic auto_pre;
   logic dqm;
   modport dev (input cke, input cs_n, input ras_n, input cas_n,
      input we_n, input ba, input auto_pre, input dqm);
   modport ctl (output cke, output cs_n, output ras_n, output cas_n,
      output we_n, output ba, output auto_pre, output dqm);
endinterface

// [core/sbl_controller.sv]
`timescale 1ns/100ps
`include "sbl_map.svh"
// Controller end: drives one requested command per edge onto the pins.
// The mask pin follows the user's mask request. RULE12 RULE16
// Refresh, self refresh and mode load only when all idle. RULE6
module sbl_controller (
   input wire logic ref_clk,
   input wire logic nrst,
   sbl_if.ctl pins,
   input wire logic req_valid,
   input wire logic [2:0] req_cmd,
   input wire logic [1:0] req_bank,
   input wire logic req_auto_pre,
   input wire logic req_cke,
   input wire logic req_mask,
   input wire logic all_idle,
   output logic req_taken
);
   // Refresh and mode load are dropped unless all banks idle. RULE6 RULE8
   wire needs_idle = req_cmd == sbl_pkg::SBL_CMD_REFRESH
      || req_cmd == sbl_pkg::SBL_CMD_LOAD_MODE;
   wire legal = req_valid && (!needs_idle || all_idle);
   // Registered pin drive; inhibit when nothing legal is requested.
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
      begin
         pins.cke <= 1'b0;
         pins.cs_n <= 1'b1;
         pins.ras_n <= 1'b1;
         pins.cas_n <= 1'b1;
         pins.we_n <= 1'b1;
         pins.ba <= 2'h0;
         pins.auto_pre <= 1'b0;
         pins.dqm <= 1'b0;
         req_taken <= 1'b0;
      end
      else
      begin
         pins.cke <= req_cke;
         pins.cs_n <= !legal;
         {pins.ras_n, pins.cas_n, pins.we_n} <= legal ? req_cmd : 3'h7;
         pins.ba <= req_bank;
         pins.auto_pre <= req_auto_pre;
         pins.dqm <= req_mask;
         req_taken <= legal;
      end
endmodule // sbl_controller

// [verif/sbl_chk_props.sv]
`timescale 1ns/100ps
// Watches the shared command pins and the device state beside them.
module sbl_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [11:0] bank_state,
   input wire logic [2:0] mode,
   input wire logic cmd_accept
);
   // Pin decode and mode flags, shared so each property stays short.
   wire logic [2:0] code = {ras_n, cas_n, we_n};
   wire logic quiet = cs_n || (code == 3'h7);
   wire logic work = !cs_n && (code inside {3'h3, 3'h5, 3'h4, 3'h2});
   wire logic refr = !cs_n && (code inside {3'h1, 3'h0});
   wire logic md_norm = (mode == sbl_pkg::SBL_MD_NORMAL);
   wire logic md_pd = (mode == sbl_pkg::SBL_MD_POWER_DOWN);
   wire logic md_sx = (mode == sbl_pkg::SBL_MD_SR_EXIT);
   wire logic md_sus = (mode == sbl_pkg::SBL_MD_SUSPEND);
   wire logic md_low = md_pd || md_sus ||
      (mode == sbl_pkg::SBL_MD_SELF_REFRESH);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Low clock enable seen long enough that the device must be frozen.
   sequence s_held_low;
      !cke [*4] ##1 (!cke && md_low);
   endsequence
   // The exit mode must hold for at least two edges before the exit completes.
   sequence s_sr_wait;
      md_sx [*2];
   endsequence
   chk_quiet_idle: assert property (quiet [*6] |-> !cmd_accept)
      else $error("Command accepted while pins were quiet.");
   chk_cross_accept: assert property ((work && cke && $past(cke) &&
      md_norm) |-> ##[1:5] cmd_accept)
      else $error("Cross-bank command was not accepted.");
   chk_reset_idle: assert property ($rose(nrst) |->
      bank_state == 12'h0 && md_norm)
      else $error("Banks not idle after reset.");
   chk_refresh_idle: assert property (refr |-> bank_state == 12'h0)
      else $error("Refresh or mode load sent with a bank open.");
   chk_low_hold: assert property (s_held_low |=> $stable(mode) &&
      !cmd_accept)
      else $error("Low-power mode left while clock enable low.");
   chk_pd_exit: assert property ((md_pd && cke) |-> ##[1:4] md_norm)
      else $error("Power-down exit too slow.");
   chk_suspend_exit: assert property ((md_sus && cke) |->
      ##[1:4] !md_sus)
      else $error("Clock suspend not left after clock enable rose.");
   chk_sr_exit: assert property ($rose(md_sx) |->
      s_sr_wait ##[1:6] md_norm)
      else $error("Self refresh exit time wrong.");
   // Per-bank timing of the transient states.
   for (genvar g = 0; g < 4; g++)
   begin : g_bank
      chk_act_done: assert property ((bank_state[3*g+:3] ==
         sbl_pkg::SBL_BK_ACTIVATING) |-> ##[1:3]
         (bank_state[3*g+:3] == sbl_pkg::SBL_BK_ACTIVE))
         else $error("Activating bank never became active.");
      chk_pre_done: assert property ((bank_state[3*g+:3] ==
         sbl_pkg::SBL_BK_PRECHARGING) |-> ##[1:4]
         (bank_state[3*g+:3] == sbl_pkg::SBL_BK_IDLE))
         else $error("Precharging bank never became idle.");
   end
endmodule // sbl_chk

// [verif/tb_top.sv]
`timescale 1ns/100ps
// Joins controller and device through one interface and drives the user side.
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_cmd = 3'h7;
   logic [1:0] req_bank = 2'h0;
   logic req_auto_pre = 1'b0;
   logic req_cke = 1'b0;
   logic req_mask = 1'b0;
   logic req_taken, data_out_valid, data_in_take, cmd_accept;
   logic [11:0] bank_state;
   logic [2:0] mode;
   logic [1:0] data_out_bank, data_in_bank;
   int rd_cnt [4];
   int wr_cnt [4];
   int taken_cnt = 0;
   int mismatches = 0;
   int n_tests = 0;
   wire logic all_idle = (bank_state == 12'h0);
   sbl_if pins ();
   sbl_controller u_sbl_controller (.ref_clk(ref_clk), .nrst(nrst),
      .pins(pins), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_bank(req_bank), .req_auto_pre(req_auto_pre), .req_cke(req_cke),
      .req_mask(req_mask), .all_idle(all_idle), .req_taken(req_taken));
   sbl_device u_sbl_device (.ref_clk(ref_clk), .nrst(nrst), .pins(pins),
      .bank_state(bank_state), .mode(mode),
      .data_out_valid(data_out_valid), .data_out_bank(data_out_bank),
      .data_in_take(data_in_take), .data_in_bank(data_in_bank),
      .cmd_accept(cmd_accept));
   sbl_chk u_sbl_chk (.ref_clk(ref_clk), .nrst(nrst), .cke(pins.cke),
      .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
      .we_n(pins.we_n), .bank_state(bank_state), .mode(mode),
      .cmd_accept(cmd_accept));
   // Free-running clock; half period is 12.5 ns.
   always #12.5 ref_clk = ~ref_clk;
   // Pulses stand one cycle, so each is counted at exactly one edge.
   always @(posedge ref_clk)
   begin
      if (data_out_valid === 1'b1) rd_cnt[data_out_bank]++;
      if (data_in_take === 1'b1) wr_cnt[data_in_bank]++;
      if (req_taken === 1'b1) taken_cnt++;
   end
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Valid stays up between back-to-back calls; idle lowers it.
   task automatic cmd(input logic [2:0] c, input logic [1:0] b,
      input logic ap);
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_auto_pre = ap;
   endtask
   task automatic idle(input int n);
      @(negedge ref_clk);
      req_valid = 1'b0;
      req_cmd = 3'h7;
      repeat (n) @(negedge ref_clk);
   endtask
   // Bank index 4 selects the mode; a wait that runs out ends the run.
   task automatic wait_for(input int b, input logic [2:0] st);
      logic [2:0] v;
      for (int i = 0; i < 60; i++)
      begin
         @(negedge ref_clk);
         v = (b == 4) ? mode : bank_state[3*b+:3];
         if (v === st) break;
      end
      cmp("state", st, v);
      if (v !== st) print_verdict;
   endtask
   task automatic clr;
      rd_cnt = '{0, 0, 0, 0};
      wr_cnt = '{0, 0, 0, 0};
   endtask
   // Bank 1 bursts, bank 0 cuts it two edges later.
   task automatic cut(input logic [2:0] c1, input logic [2:0] c2,
      input logic ap);
      clr();
      cmd(c1, 2'h1, ap);
      req_mask = (c1 == 3'h5 && c2 == 3'h4);
      idle(0);
      cmd(c2, 2'h0, 1'b0);
      req_mask = 1'b0;
      idle(12);
   endtask
   task automatic t_open;
      cmp("reset banks", 12'h0, bank_state);
      req_cke = 1'b1;
      idle(4);
      cmd(sbl_pkg::SBL_CMD_ACTIVE, 2'h0, 1'b0);
      cmd(sbl_pkg::SBL_CMD_ACTIVE, 2'h1, 1'b0);
      idle(0);
      wait_for(0, sbl_pkg::SBL_BK_ACTIVE);
      wait_for(1, sbl_pkg::SBL_BK_ACTIVE);
      $display("Test open done");
   endtask
   task automatic t_cuts;
      cut(sbl_pkg::SBL_CMD_READ, sbl_pkg::SBL_CMD_READ, 1'b0);
      cmp("read cut", 2, rd_cnt[1]);
      cmp("read new", 4, rd_cnt[0]);
      cut(sbl_pkg::SBL_CMD_WRITE, sbl_pkg::SBL_CMD_WRITE, 1'b0);
      cmp("write cut", 2, wr_cnt[1]);
      cut(sbl_pkg::SBL_CMD_WRITE, sbl_pkg::SBL_CMD_READ, 1'b0);
      cmp("write by read", 2, wr_cnt[1]);
      cmp("read after", 4, rd_cnt[0]);
      cut(sbl_pkg::SBL_CMD_READ, sbl_pkg::SBL_CMD_WRITE, 1'b0);
      cmp("write after read", 4, wr_cnt[0]);
      clr();
      cmd(sbl_pkg::SBL_CMD_READ, 2'h1, 1'b0);
      cmd(sbl_pkg::SBL_CMD_PRECHARGE, 2'h0, 1'b0);
      idle(12);
      cmp("read kept", 4, rd_cnt[1]);
      cmp("bank0 closed", sbl_pkg::SBL_BK_IDLE, bank_state[2:0]);
      $display("Test cuts done");
   endtask
   // Each auto precharge cut must leave bank 1 idle; reopen after each.
   task automatic t_auto;
      logic [2:0] c1 [4] = '{3'h5, 3'h5, 3'h4, 3'h4};
      logic [2:0] c2 [4] = '{3'h5, 3'h4, 3'h5, 3'h4};
      cmd(sbl_pkg::SBL_CMD_ACTIVE, 2'h0, 1'b0);
      idle(4);
      for (int k = 0; k < 4; k++)
      begin
         cut(c1[k], c2[k], 1'b1);
         cmp("ap bank idle", 3'h0, bank_state[5:3]);
         cmp("ap beats", 2, rd_cnt[1] + wr_cnt[1]);
         cmd(sbl_pkg::SBL_CMD_ACTIVE, 2'h1, 1'b0);
         idle(4);
      end
      $display("Test auto precharge done");
   endtask
   task automatic t_low_power;
      int tk;
      tk = taken_cnt;
      cmd(sbl_pkg::SBL_CMD_REFRESH, 2'h0, 1'b0);
      idle(4);
      cmp("refused", tk, taken_cnt);
      cmd(sbl_pkg::SBL_CMD_PRECHARGE, 2'h0, 1'b0);
      cmd(sbl_pkg::SBL_CMD_PRECHARGE, 2'h1, 1'b0);
      idle(6);
      req_cke = 1'b0;
      wait_for(4, sbl_pkg::SBL_MD_POWER_DOWN);
      idle(6);
      cmp("pd held", sbl_pkg::SBL_MD_POWER_DOWN, mode);
      req_cke = 1'b1;
      wait_for(4, sbl_pkg::SBL_MD_NORMAL);
      idle(4);
      cmd(sbl_pkg::SBL_CMD_REFRESH, 2'h0, 1'b0);
      req_cke = 1'b0;
      wait_for(4, sbl_pkg::SBL_MD_SELF_REFRESH);
      idle(6);
      req_cke = 1'b1;
      wait_for(4, sbl_pkg::SBL_MD_SR_EXIT);
      wait_for(4, sbl_pkg::SBL_MD_NORMAL);
      $display("Test low power done");
   endtask
   task automatic t_suspend;
      cmd(sbl_pkg::SBL_CMD_ACTIVE, 2'h0, 1'b0);
      idle(4);
      clr();
      cmd(sbl_pkg::SBL_CMD_READ, 2'h0, 1'b0);
      idle(1);
      req_cke = 1'b0;
      wait_for(4, sbl_pkg::SBL_MD_SUSPEND);
      idle(4);
      req_cke = 1'b1;
      wait_for(4, sbl_pkg::SBL_MD_NORMAL);
      idle(12);
      cmp("resumed beats", 4, rd_cnt[0]);
      $display("Test suspend done");
   endtask
   // Reset held for ten cycles, then the scenarios in turn.
   initial
   begin
      clr();
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      t_open();
      t_cuts();
      t_auto();
      t_low_power();
      t_suspend();
      print_verdict();
   end
endmodule // tb_top
